/* File: verilog/tws_consts.vh */
// Constants shared by the two-wire register slave
`ifndef TWS_CONSTS_VH
`define TWS_CONSTS_VH

// ---------------------------------------------------------------
// Bus addressing
// ---------------------------------------------------------------
`define TWS_SLAVE_ADDR_LO 7'h40
`define TWS_SLAVE_ADDR_HI 7'h41
`define TWS_MCODE_TOP 5'h01
`define TWS_RW_READ 1'b1

// ---------------------------------------------------------------
// Byte framing
// ---------------------------------------------------------------
`define TWS_BIT_CNT_W 4
`define TWS_BITS_PER_BYTE 4'h8
`define TWS_BIT_CNT_ZERO 4'h0
`define TWS_BIT_STEP 4'h1
`define TWS_PTR_STEP 8'h01
`define TWS_PTR_RESET 8'h00
`define TWS_BYTE_ZERO 8'h00

// ---------------------------------------------------------------
// Kind of byte being received
// ---------------------------------------------------------------
`define TWS_KIND_SADDR 2'h0
`define TWS_KIND_PTR 2'h1
`define TWS_KIND_DATA 2'h2

// ---------------------------------------------------------------
// Default map of valid register locations, one bit per address
// ---------------------------------------------------------------
`define TWS_VALID_MAP_DEF 256'hffffffff

`endif

/* File: verilog/tws_sync.v */
// Pin synchroniser and bus condition detector for the two-wire slave
`timescale 1ns/1ps
module tws_sync (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Raw pins: 0 serial clock, 1 serial data, 2 address strap
    input wire [2:0] pin_in,
    // Synchronised levels
    output wire scl_s,
    output wire sda_s,
    output wire strap_s,
    // Single-cycle events
    output wire scl_rise,
    output wire scl_fall,
    output wire start_det,
    output wire stop_det
);

    // ---------------------------------------------------------------
    // Two flip-flops per pin, plus one delayed copy for edges
    // ---------------------------------------------------------------
    reg [2:0] meta_q;
    reg [2:0] sync_q;
    reg [2:0] prev_q;

    genvar i;
    generate
        for (i = 0; i < 3; i = i + 1)
        begin : g_pin
            always @(posedge clk or negedge rst_n)
            begin
                if (!rst_n)
                begin
                    meta_q[i] <= 1'b1;
                    sync_q[i] <= 1'b1;
                    prev_q[i] <= 1'b1;
                end
                else
                begin
                    meta_q[i] <= pin_in[i];
                    sync_q[i] <= meta_q[i];
                    prev_q[i] <= sync_q[i];
                end
            end
        end
    endgenerate

    assign scl_s = sync_q[0];
    assign sda_s = sync_q[1];
    assign strap_s = sync_q[2];
    assign scl_rise = sync_q[0] & ~prev_q[0];
    assign scl_fall = ~sync_q[0] & prev_q[0];
    // Data moving while the clock stays high is a bus condition, not data
    assign start_det = sync_q[0] & prev_q[0] & prev_q[1] & ~sync_q[1];
    assign stop_det = sync_q[0] & prev_q[0] & ~prev_q[1] & sync_q[1];

endmodule

/* File: verilog/tws_slave.v */
// Two-wire serial slave giving a bus master byte access to a register space
//
// Notes on behaviour
// - Acts only as slave; master makes clock, START and STOP.
// - Never holds the clock low; only the data line is driven.
// - Pointer advances after every byte moved, valid location or not.
// - Invalid pointer byte gets not-acknowledge; transfer may still continue.
// - Reads from an invalid location return all zero bits.
// - Sequential reads wrap from the top address to the bottom.
// - Write data to an invalid location is refused and not stored.
// - Write data to a valid location is stored and acknowledged.
// - Page writes wrap past the top address.
// - Data changes during clock high are START or STOP, never data.
// - Bus is idle while both lines are high.
// - START is data falling while clock is high.
// - STOP is data rising while clock is high.
// - One bit per clock; change while low, sample while high.
// - Any number of bytes between START and STOP.
// - Eight-bit bytes, each followed by an acknowledge clock.
// - Slave address 40h with strap low, 41h with strap high.
// - First written byte loads pointer; later bytes are data, MSB first.
// - Read starts at current pointer and ends on master not-acknowledge.
// - Unacknowledged master code enters high-speed mode until STOP.
`timescale 1ns/1ps
`include "tws_consts.vh"

module tws_slave #(
    parameter [255:0] VALID_MAP = `TWS_VALID_MAP_DEF
) (
    // Clock and reset
    input wire clk,
    input wire rst_n,
    // Serial bus pins
    input wire scl_in,
    input wire sda_in,
    output wire sda_out,
    output wire sda_oe,
    // Address strap pin
    input wire addr_sel,
    // Register space access
    output wire [7:0] reg_addr,
    output wire [7:0] reg_wdata,
    output wire reg_wr,
    output wire reg_rd,
    input wire [7:0] reg_rdata,
    // Status
    output wire bus_busy,
    output wire hs_mode
);

    // ---------------------------------------------------------------
    // States
    // ---------------------------------------------------------------
    localparam [5:0] ST_IDLE = 6'h01;
    localparam [5:0] ST_RX = 6'h02;
    localparam [5:0] ST_ACK = 6'h04;
    localparam [5:0] ST_TX = 6'h08;
    localparam [5:0] ST_TXACK = 6'h10;
    localparam [5:0] ST_SKIP = 6'h20;

    wire scl_s;
    wire sda_s;
    wire strap_s;
    wire scl_rise;
    wire scl_fall;
    wire start_det;
    wire stop_det;

    tws_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_in({addr_sel, sda_in, scl_in}),
        .scl_s(scl_s),
        .sda_s(sda_s),
        .strap_s(strap_s),
        .scl_rise(scl_rise),
        .scl_fall(scl_fall),
        .start_det(start_det),
        .stop_det(stop_det)
    );

    reg [5:0] state_q;
    reg [1:0] kind_q;
    reg [3:0] cnt_q;
    reg [7:0] shift_q;
    reg [7:0] ptr_q;
    reg rw_q;
    reg ack_q;
    reg sda_oe_q;
    reg sda_out_q;
    reg [7:0] reg_addr_q;
    reg [7:0] reg_wdata_q;
    reg reg_wr_q;
    reg reg_rd_q;
    reg busy_q;
    reg hs_q;

    // ---------------------------------------------------------------
    // Decode of the byte just completed
    // ---------------------------------------------------------------
    wire [7:0] rx_byte = shift_q;
    wire [6:0] own_addr = strap_s ? `TWS_SLAVE_ADDR_HI : `TWS_SLAVE_ADDR_LO;
    wire addr_hit = (rx_byte[7:1] == own_addr);
    wire mcode_hit = (rx_byte[7:3] == `TWS_MCODE_TOP);
    wire ptr_valid = VALID_MAP[ptr_q];
    wire new_ptr_valid = VALID_MAP[rx_byte];
    wire byte_done = (cnt_q == `TWS_BITS_PER_BYTE);
    wire [7:0] ptr_next = ptr_q + `TWS_PTR_STEP;
    wire [7:0] tx_load = ptr_valid ? reg_rdata : `TWS_BYTE_ZERO;

    // Data output is only ever a pull low; serial clock is never driven
    assign sda_out = sda_out_q;
    assign sda_oe = sda_oe_q;
    assign reg_addr = reg_addr_q;
    assign reg_wdata = reg_wdata_q;
    assign reg_wr = reg_wr_q;
    assign reg_rd = reg_rd_q;
    assign bus_busy = busy_q;
    assign hs_mode = hs_q;

    // ---------------------------------------------------------------
    // Protocol engine
    // ---------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_IDLE;
            kind_q <= `TWS_KIND_SADDR;
            cnt_q <= `TWS_BIT_CNT_ZERO;
            shift_q <= `TWS_BYTE_ZERO;
            ptr_q <= `TWS_PTR_RESET;
            rw_q <= 1'b0;
            ack_q <= 1'b0;
            sda_oe_q <= 1'b0;
            sda_out_q <= 1'b0;
            reg_wdata_q <= `TWS_BYTE_ZERO;
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            busy_q <= 1'b0;
            hs_q <= 1'b0;
        end
        else
        begin
            reg_wr_q <= 1'b0;
            reg_rd_q <= 1'b0;
            if (stop_det)
            begin
                // Abort anything in flight and release the bus
                state_q <= ST_IDLE;
                sda_oe_q <= 1'b0;
                cnt_q <= `TWS_BIT_CNT_ZERO;
                busy_q <= 1'b0;
                hs_q <= 1'b0;
            end
            else if (start_det)
            begin
                // Repeated START also lands here; a partial byte is dropped
                state_q <= ST_RX;
                kind_q <= `TWS_KIND_SADDR;
                cnt_q <= `TWS_BIT_CNT_ZERO;
                sda_oe_q <= 1'b0;
                busy_q <= 1'b1;
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        sda_oe_q <= 1'b0;
                    end
                    ST_RX:
                    begin
                        if (scl_rise && !byte_done)
                        begin
                            shift_q <= {shift_q[6:0], sda_s};
                            cnt_q <= cnt_q + `TWS_BIT_STEP;
                        end
                        else if (scl_fall && byte_done)
                        begin
                            cnt_q <= `TWS_BIT_CNT_ZERO;
                            state_q <= ST_ACK;
                            case (kind_q)
                                `TWS_KIND_SADDR:
                                begin
                                    rw_q <= rx_byte[0];
                                    ack_q <= addr_hit;
                                    sda_oe_q <= addr_hit;
                                    if (!addr_hit)
                                    begin
                                        state_q <= ST_SKIP;
                                    end
                                    if (mcode_hit)
                                    begin
                                        hs_q <= 1'b1;
                                    end
                                end
                                `TWS_KIND_PTR:
                                begin
                                    ptr_q <= rx_byte;
                                    ack_q <= new_ptr_valid;
                                    sda_oe_q <= new_ptr_valid;
                                end
                                default:
                                begin
                                    ack_q <= ptr_valid;
                                    sda_oe_q <= ptr_valid;
                                    reg_wr_q <= ptr_valid;
                                    reg_wdata_q <= rx_byte;
                                    ptr_q <= ptr_next;
                                end
                            endcase
                        end
                    end
                    ST_ACK:
                    begin
                        if (scl_fall)
                        begin
                            // End of acknowledge clock: release or send first bit
                            sda_oe_q <= 1'b0;
                            if (kind_q == `TWS_KIND_SADDR && rw_q == `TWS_RW_READ)
                            begin
                                shift_q <= tx_load;
                                sda_oe_q <= ~tx_load[7];
                                reg_rd_q <= 1'b1;
                                state_q <= ST_TX;
                            end
                            else
                            begin
                                // Invalid pointer still lets the transfer go on
                                kind_q <= (kind_q == `TWS_KIND_SADDR) ?
                                    `TWS_KIND_PTR : `TWS_KIND_DATA;
                                state_q <= ST_RX;
                            end
                        end
                    end
                    ST_TX:
                    begin
                        if (scl_fall)
                        begin
                            if (cnt_q == `TWS_BITS_PER_BYTE - `TWS_BIT_STEP)
                            begin
                                cnt_q <= `TWS_BIT_CNT_ZERO;
                                sda_oe_q <= 1'b0;
                                ptr_q <= ptr_next;
                                state_q <= ST_TXACK;
                            end
                            else
                            begin
                                cnt_q <= cnt_q + `TWS_BIT_STEP;
                                shift_q <= {shift_q[6:0], 1'b0};
                                sda_oe_q <= ~shift_q[6];
                            end
                        end
                    end
                    ST_TXACK:
                    begin
                        if (scl_rise)
                        begin
                            ack_q <= ~sda_s;
                            if (sda_s)
                            begin
                                state_q <= ST_SKIP;
                            end
                        end
                        else if (scl_fall && ack_q)
                        begin
                            shift_q <= tx_load;
                            sda_oe_q <= ~tx_load[7];
                            reg_rd_q <= 1'b1;
                            state_q <= ST_TX;
                        end
                    end
                    ST_SKIP:
                    begin
                        // Not addressed or read ended: wait for START or STOP
                        sda_oe_q <= 1'b0;
                    end
                    default:
                    begin
                        state_q <= ST_IDLE;
                        sda_oe_q <= 1'b0;
                    end
                endcase
            end
        end
    end

    // ---------------------------------------------------------------
    // Register address follows the pointer one cycle late, so a write
    // strobe still sees the location it was aimed at
    // ---------------------------------------------------------------
    always @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            reg_addr_q <= `TWS_PTR_RESET;
        end
        else
        begin
            reg_addr_q <= ptr_q;
        end
    end

endmodule

/* File: verif/tws_slave_properties.sv */
// Port checker for the two-wire register slave
`timescale 1ns/1ps
`include "tws_consts.vh"
module tws_chk #(
    parameter [255:0] VALID_MAP = `TWS_VALID_MAP_DEF
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Serial bus and strap
    input wire logic scl_in,
    input wire logic sda_in,
    input wire logic sda_out,
    input wire logic sda_oe,
    input wire logic addr_sel,
    // Register side
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // Status
    input wire logic bus_busy,
    input wire logic hs_mode
);
default clocking cb @(posedge clk);
endclocking
default disable iff (!rst_n);
// ----------------------------------------
// Bus conditions seen on the raw pins
// ----------------------------------------
sequence s_start;
    scl_in && $past(scl_in) && $fell(sda_in);
endsequence
sequence s_stop;
    scl_in && $past(scl_in) && $rose(sda_in);
endsequence
property p_odrain; sda_out == 1'b0; endproperty
a_odrain: assert property (p_odrain) else $error("data drive value not low");
property p_busy_set; s_start |-> ##[1:6] bus_busy; endproperty
a_busy_set: assert property (p_busy_set) else $error("busy not set by start");
property p_busy_clr; s_stop |-> ##[1:6] !bus_busy; endproperty
a_busy_clr: assert property (p_busy_clr) else $error("busy not cleared by stop");
property p_hs_clr; s_stop |-> ##[1:6] !hs_mode; endproperty
a_hs_clr: assert property (p_hs_clr) else $error("high speed mode kept after stop");
// Pulling data low while the clock is high would fake a start
property p_oe_low; $rose(sda_oe) |-> !scl_in && !$past(scl_in, 3); endproperty
a_oe_low: assert property (p_oe_low) else $error("data pulled low outside clock low");
property p_wr_step; reg_wr |-> bus_busy && !scl_in ##1 !reg_wr; endproperty
a_wr_step: assert property (p_wr_step) else $error("write strobe misplaced");
property p_wr_valid; reg_wr |-> VALID_MAP[reg_addr]; endproperty
a_wr_valid: assert property (p_wr_valid) else $error("write to invalid location");
property p_wr_ack; reg_wr |-> ##[0:2] sda_oe; endproperty
a_wr_ack: assert property (p_wr_ack) else $error("stored byte not acknowledged");
property p_ptr_inc; reg_wr |=> reg_addr == $past(reg_addr) + 8'h01; endproperty
a_ptr_inc: assert property (p_ptr_inc) else $error("pointer did not advance");
property p_rd_pulse; reg_rd |-> bus_busy ##1 !reg_rd; endproperty
a_rd_pulse: assert property (p_rd_pulse) else $error("read pulse misplaced");
property p_idle; !bus_busy |-> !reg_wr && !reg_rd; endproperty
a_idle: assert property (p_idle) else $error("register access while bus idle");
endmodule

bind tws_slave tws_chk #(.VALID_MAP(VALID_MAP)) u_chk (
    .clk(clk), .rst_n(rst_n), .scl_in(scl_in), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_sel(addr_sel),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_busy(bus_busy),
    .hs_mode(hs_mode)
);

/* File: verif/tws_bus_master.sv */
// Two-wire bus master model: clock and open-drain data drive
`timescale 1ns/1ps
module tws_bus_master (
    // Bus lines
    output reg scl,
    output reg sda_drv,
    input wire sda
);
initial
begin
    scl = 1'b1;
    sda_drv = 1'b1;
end
// ----------------------------------------
// Conditions; clock stands high between frames
// ----------------------------------------
task start;
    begin
        #50 sda_drv = 1'b1;
        #350 scl = 1'b1;
        #200 sda_drv = 1'b0;
        #200 scl = 1'b0;
    end
endtask
task stop;
    begin
        #50 sda_drv = 1'b0;
        #350 scl = 1'b1;
        #200 sda_drv = 1'b1;
        #200;
    end
endtask
// ----------------------------------------
// One bit: change while low, sample mid high
// ----------------------------------------
task xfer_bit(input b, output r);
    begin
        #50 sda_drv = b;
        #150 scl = 1'b1;
        #100 r = sda;
        // A 400 ns bit period stays inside the high-speed clock limit
        #100 scl = 1'b0;
    end
endtask
task wbyte(input [7:0] d, output ack);
    integer i;
    reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            xfer_bit(d[i], r);
        xfer_bit(1'b1, r);
        ack = ~r;
    end
endtask
task rbyte(input ack, output [7:0] d);
    integer i;
    reg r;
    begin
        for (i = 7; i >= 0; i = i - 1)
            xfer_bit(1'b1, d[i]);
        xfer_bit(~ack, r);
    end
endtask
endmodule

/* File: verif/tws_slave_tb.sv */
// Self-checking bench for the two-wire register slave
`timescale 1ns/1ps
module tws_slave_tb;
reg clk;
reg rst_n;
reg addr_sel;
reg [7:0] ack;
reg [7:0] d;
reg [7:0] mem [0:255];
integer error_cnt;
integer checks_done;
integer i;
reg [7:0] rd_cnt = 8'h00;
reg [7:0] rd_base;
wire scl, sda_drv, sda, sda_oe, sda_out, reg_wr, reg_rd, bus_busy, hs_mode;
wire [7:0] reg_addr, reg_wdata, reg_rdata;
// Pull-up: a released line reads high
assign sda = sda_drv & ~sda_oe;
assign reg_rdata = mem[reg_addr];
tws_slave uut (
    .clk(clk), .rst_n(rst_n), .scl_in(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .addr_sel(addr_sel), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .bus_busy(bus_busy),
    .hs_mode(hs_mode)
);
tws_bus_master m (.scl(scl), .sda_drv(sda_drv), .sda(sda));
initial
begin
    clk = 1'b0;
    forever #25 clk = ~clk;
end
always @(posedge clk)
    if (reg_wr)
        mem[reg_addr] <= reg_wdata;
// Count read loads so the bench can judge the read strobe
always @(posedge clk)
    if (reg_rd === 1'b1)
        rd_cnt <= rd_cnt + 8'h01;
function [7:0] init_val(input [7:0] a);
    init_val = a ^ 8'h5a;
endfunction
task chk(input [7:0] got, input [7:0] exp);
    begin
        checks_done = checks_done + 1;
        if (got !== exp)
        begin
            error_cnt = error_cnt + 1;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    end
endtask
task test_done;
    begin
        $display("errors %0d checks %0d", error_cnt, checks_done);
        if (error_cnt == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    end
endtask
// ----------------------------------------
// Scenarios
// ----------------------------------------
task t_write;
    begin
        m.start;
        chk({7'h00, bus_busy}, 8'h01);
        m.wbyte(8'h80, ack[0]);
        chk(ack, 8'h01);
        m.wbyte(8'h1e, ack[0]);
        chk(ack, 8'h01);
        m.wbyte(8'ha1, ack[0]);
        chk(ack, 8'h01);
        m.wbyte(8'hb2, ack[0]);
        chk(ack, 8'h01);
        m.wbyte(8'hc3, ack[0]);
        chk(ack, 8'h00);
        m.stop;
        chk({7'h00, bus_busy}, 8'h00);
        chk(mem[8'h1e], 8'ha1);
        chk(mem[8'h1f], 8'hb2);
        chk(mem[8'h20], init_val(8'h20));
    end
endtask
task t_wrap;
    begin
        m.start;
        m.wbyte(8'h80, ack[0]);
        chk(ack, 8'h01);
        m.wbyte(8'hff, ack[0]);
        chk(ack, 8'h00);
        m.wbyte(8'h5a, ack[0]);
        chk(ack, 8'h00);
        m.wbyte(8'h66, ack[0]);
        chk(ack, 8'h01);
        m.stop;
        chk(mem[8'hff], init_val(8'hff));
        chk(mem[8'h00], 8'h66);
    end
endtask
task t_read;
    begin
        rd_base = rd_cnt;
        m.start;
        m.wbyte(8'h80, ack[0]);
        chk(ack, 8'h01);
        m.wbyte(8'hfe, ack[0]);
        chk(ack, 8'h00);
        m.start;
        m.wbyte(8'h81, ack[0]);
        chk(ack, 8'h01);
        m.rbyte(1'b1, d);
        chk(d, 8'h00);
        m.rbyte(1'b1, d);
        chk(d, 8'h00);
        m.rbyte(1'b0, d);
        chk(d, 8'h66);
        m.stop;
        m.start;
        m.wbyte(8'h81, ack[0]);
        chk(ack, 8'h01);
        m.rbyte(1'b0, d);
        chk(d, init_val(8'h01));
        m.stop;
        chk({7'h00, bus_busy}, 8'h00);
        // One load per byte sent, none after the closing not-acknowledge
        chk(rd_cnt - rd_base, 8'h04);
    end
endtask
task t_strap;
    begin
        addr_sel = 1'b1;
        m.start;
        m.wbyte(8'h80, ack[0]);
        chk(ack, 8'h00);
        m.stop;
        m.start;
        m.wbyte(8'h82, ack[0]);
        chk(ack, 8'h01);
        m.wbyte(8'h05, ack[0]);
        chk(ack, 8'h01);
        m.stop;
        addr_sel = 1'b0;
    end
endtask
task t_hs_abort;
    begin
        m.start;
        m.wbyte(8'h08, ack[0]);
        chk(ack, 8'h00);
        chk({7'h00, hs_mode}, 8'h01);
        m.start;
        m.wbyte(8'h80, ack[0]);
        chk(ack, 8'h01);
        m.wbyte(8'h05, ack[0]);
        chk(ack, 8'h01);
        for (i = 0; i < 4; i = i + 1)
            m.xfer_bit(1'b0, ack[0]);
        m.stop;
        chk({7'h00, hs_mode}, 8'h00);
        chk(mem[8'h05], init_val(8'h05));
        m.start;
        m.wbyte(8'h80, ack[0]);
        chk(ack, 8'h01);
        m.stop;
    end
endtask
// ----------------------------------------
// Main sequence and hang guard
// ----------------------------------------
initial
begin
    error_cnt = 0;
    checks_done = 0;
    rst_n = 1'b0;
    addr_sel = 1'b0;
    ack = 8'h00;
    for (i = 0; i < 256; i = i + 1)
        mem[i] = init_val(i[7:0]);
    repeat (4) @(posedge clk);
    @(negedge clk) rst_n = 1'b1;
    repeat (8) @(negedge clk);
    t_write;
    t_wrap;
    t_read;
    t_strap;
    t_hs_abort;
    test_done;
end
initial
begin
    #3000000;
    error_cnt = error_cnt + 1;
    test_done;
end
endmodule
